// ### common/cal_bank_pkg.sv
// constants and types of the colour calibration register bank
package cal_bank_pkg;
   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [6:0] IDX_CFG_LAST = 7'h5f;
   localparam logic [6:0] IDX_DITHER = 7'h5d;
   localparam logic [6:0] IDX_OFS_DLY = 7'h5e;
   localparam logic [6:0] IDX_CHK_EN = 7'h46;
   localparam logic [6:0] IDX_COMM_TAG = 7'h66;
   localparam logic [6:0] IDX_CH1_TRIM = 7'h77;
   localparam logic [6:0] IDX_CH2_TRIM = 7'h78;
   localparam logic [6:0] IDX_SET_A_TAG = 7'h79;
   localparam logic [6:0] IDX_STATUS = 7'h7f;
   localparam int IDX_W = 7;
   localparam int NUM_REGS = 128;
   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int CHK_EN_BIT = 0;
   localparam int SET_A_BIT = 7;
   localparam int TRIM_MSB = 5;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_CH1 = 8'hbf;
   localparam logic [7:0] MASK_CH2 = 8'h3f;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_POLY_DEF = 8'h07;
   // ----------------------------------------
   // gain: q1.10, step 5/1024 is about 0.00488
   // ----------------------------------------
   localparam int GAIN_W = 12;
   localparam logic signed [11:0] GAIN_ONE = 12'sh400;
   localparam logic signed [11:0] TRIM_STEP = 12'sh005;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_CFG = 3'b001,
      ST_SET_A = 3'b010,
      ST_LATCH = 3'b100
   } scan_state_t;
   typedef struct packed {
      logic [GAIN_W-1:0] ch1;
      logic [GAIN_W-1:0] ch2;
   } gain_pair_t;
   typedef struct packed {
      logic set_a_active;
      logic set_a_ok;
      logic cfg_ok;
   } check_status_t;
endpackage

// ### rtl/color_calibration_register_bank.sv
// apb register bank with configuration check and channel trim gains
//
// Local design decision: register access over APB.
`timescale 1ns/100ps

// Function
// - config tag checked only when enable bit set
// - config tag equals crc of locations 0..95
// - crc covers factory reserved bytes too
// - channel-one bit seven selects trim set a
// - channel-one low six bits signed trim
// - channel-one gain one plus trim times 0.00488
// - channel-two low six bits signed trim
// - channel-two gain one plus trim times 0.00488
// - set a tag is crc of 119,120
module color_calibration_register_bank #(
   parameter int ADDR_W = 12,
   parameter logic [7:0] CRC_POLY = cal_bank_pkg::CRC_POLY_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output cal_bank_pkg::gain_pair_t gain,
   output cal_bank_pkg::check_status_t status
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (ADDR_W < cal_bank_pkg::IDX_W + 2) begin : g_bad_addr
      $error("address bus too narrow for the register map");
   end

   // paddr is a byte address inside a 32-bit apb space
   if (ADDR_W > 32) begin : g_wide_addr
      $error("address bus wider than the apb address space");
   end

   // an even polynomial never folds back into bit zero
   if (CRC_POLY[0] == 1'b0) begin : g_even_poly
      $error("crc polynomial needs its lowest bit set");
   end

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   function automatic logic [7:0] wmask(input logic [6:0] idx);
      logic [7:0] m;
      m = cal_bank_pkg::MASK_NONE;
      if (idx <= cal_bank_pkg::IDX_CFG_LAST) begin
         m = cal_bank_pkg::MASK_FULL;
      end else if (idx == cal_bank_pkg::IDX_COMM_TAG) begin
         m = cal_bank_pkg::MASK_FULL;
      end else if (idx == cal_bank_pkg::IDX_CH1_TRIM) begin
         m = cal_bank_pkg::MASK_CH1;
      end else if (idx == cal_bank_pkg::IDX_CH2_TRIM) begin
         m = cal_bank_pkg::MASK_CH2;
      end else if (idx == cal_bank_pkg::IDX_SET_A_TAG) begin
         m = cal_bank_pkg::MASK_FULL;
      end
      return m;
   endfunction

   function automatic logic [7:0] crc_byte(
      input logic [7:0] crc,
      input logic [7:0] data,
      input logic [7:0] poly
   );
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ poly) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [11:0] trim_gain(input logic [5:0] t);
      logic signed [11:0] ext;
      logic signed [11:0] prod;
      ext = {{6{t[cal_bank_pkg::TRIM_MSB]}}, t};
      prod = 12'(ext * cal_bank_pkg::TRIM_STEP);
      return 12'(cal_bank_pkg::GAIN_ONE + prod);
   endfunction

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire logic [6:0] idx = paddr[8:2];
   wire logic high_bits_set;
   wire logic lane_bits_set = |paddr[1:0];
   wire logic [7:0] idx_mask = wmask(idx);
   wire logic is_status = (idx == cal_bank_pkg::IDX_STATUS);
   wire logic mapped = (idx_mask != cal_bank_pkg::MASK_NONE) | is_status;
   wire logic addr_err = high_bits_set | lane_bits_set | ~mapped;
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable & pready;
   wire logic wr_go = access & pwrite & ~pslverr;

   if (ADDR_W > cal_bank_pkg::IDX_W + 2) begin : g_high
      assign high_bits_set = |paddr[ADDR_W-1:cal_bank_pkg::IDX_W+2];
   end else begin : g_nohigh
      assign high_bits_set = 1'b0;
   end

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [7:0] regs_q [cal_bank_pkg::NUM_REGS];

   // unmapped slots keep their reset constant and fold away in synthesis
   for (genvar g = 0; g < cal_bank_pkg::NUM_REGS; g++) begin : g_reg
      localparam logic [7:0] M = wmask(7'(g));
      wire logic hit = wr_go & (idx == 7'(g));
      wire logic [7:0] nxt = hit ? (pwdata[7:0] & M) : regs_q[g];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            regs_q[g] <= cal_bank_pkg::REG_RESET;
         end else begin
            regs_q[g] <= nxt;
         end
      end
   end

   // ----------------------------------------
   // field views
   // ----------------------------------------
   wire logic [7:0] ch1_reg = regs_q[cal_bank_pkg::IDX_CH1_TRIM];
   wire logic [7:0] ch2_reg = regs_q[cal_bank_pkg::IDX_CH2_TRIM];
   wire logic [7:0] comm_tag = regs_q[cal_bank_pkg::IDX_COMM_TAG];
   wire logic [7:0] set_a_tag = regs_q[cal_bank_pkg::IDX_SET_A_TAG];
   wire logic [7:0] chk_reg = regs_q[cal_bank_pkg::IDX_CHK_EN];
   wire logic chk_en = chk_reg[cal_bank_pkg::CHK_EN_BIT];
   wire logic set_a_sel = ch1_reg[cal_bank_pkg::SET_A_BIT];
   wire logic [5:0] ch1_trim = ch1_reg[cal_bank_pkg::TRIM_MSB:0];
   wire logic [5:0] ch2_trim = ch2_reg[cal_bank_pkg::TRIM_MSB:0];

   // ----------------------------------------
   // background crc scan
   // ----------------------------------------
   // a full sweep takes 99 cycles, so a new write is reflected in the
   // status within two sweeps; the gains need a clean last set a check but take new trim bytes at once.
   cal_bank_pkg::scan_state_t state_q, state_d;
   logic [6:0] scan_q, scan_d;
   logic [7:0] crc_cfg_q, crc_cfg_d;
   logic [7:0] crc_a_q, crc_a_d;
   logic cfg_ok_q, cfg_ok_d;
   logic a_ok_q, a_ok_d;

   wire logic [7:0] scan_byte = regs_q[scan_q];
   wire logic [7:0] crc_cfg_nxt = crc_byte(crc_cfg_q, scan_byte, CRC_POLY);
   wire logic [7:0] crc_a_nxt = crc_byte(crc_a_q, scan_byte, CRC_POLY);
   wire logic cfg_end = (scan_q == cal_bank_pkg::IDX_CFG_LAST);
   wire logic a_end = (scan_q == cal_bank_pkg::IDX_CH2_TRIM);
   wire logic cfg_match = (crc_cfg_q == comm_tag);
   wire logic a_match = (crc_a_q == set_a_tag);

   always_comb begin
      state_d = state_q;
      scan_d = scan_q;
      crc_cfg_d = crc_cfg_q;
      crc_a_d = crc_a_q;
      cfg_ok_d = cfg_ok_q;
      a_ok_d = a_ok_q;
      unique case (state_q)
         cal_bank_pkg::ST_CFG: begin
            crc_cfg_d = crc_cfg_nxt;
            scan_d = 7'(scan_q + 7'h01);
            if (cfg_end) begin
               state_d = cal_bank_pkg::ST_SET_A;
               scan_d = cal_bank_pkg::IDX_CH1_TRIM;
            end
         end
         cal_bank_pkg::ST_SET_A: begin
            // crc over the two trim bytes
            crc_a_d = crc_a_nxt;
            scan_d = 7'(scan_q + 7'h01);
            if (a_end) begin
               state_d = cal_bank_pkg::ST_LATCH;
            end
         end
         cal_bank_pkg::ST_LATCH: begin
            cfg_ok_d = ~chk_en | cfg_match;
            a_ok_d = a_match;
            crc_cfg_d = cal_bank_pkg::CRC_INIT;
            crc_a_d = cal_bank_pkg::CRC_INIT;
            scan_d = 7'h00;
            state_d = cal_bank_pkg::ST_CFG;
         end
         default: begin
            state_d = cal_bank_pkg::ST_LATCH;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= cal_bank_pkg::ST_CFG;
         scan_q <= 7'h00;
         crc_cfg_q <= cal_bank_pkg::CRC_INIT;
         crc_a_q <= cal_bank_pkg::CRC_INIT;
         cfg_ok_q <= 1'b0;
         a_ok_q <= 1'b0;
      end else begin
         state_q <= state_d;
         scan_q <= scan_d;
         crc_cfg_q <= crc_cfg_d;
         crc_a_q <= crc_a_d;
         cfg_ok_q <= cfg_ok_d;
         a_ok_q <= a_ok_d;
      end
   end

   // ----------------------------------------
   // channel gains
   // ----------------------------------------
   // set a is used only while selected and its tag matches
   wire logic use_a = set_a_sel & a_ok_q;
   wire logic [11:0] ch1_gain_d = use_a ? trim_gain(ch1_trim)
                                        : 12'(cal_bank_pkg::GAIN_ONE);
   wire logic [11:0] ch2_gain_d = use_a ? trim_gain(ch2_trim)
                                        : 12'(cal_bank_pkg::GAIN_ONE);
   wire cal_bank_pkg::gain_pair_t gain_d = {ch1_gain_d, ch2_gain_d};
   wire cal_bank_pkg::check_status_t status_d = {use_a, a_ok_q, cfg_ok_q};
   cal_bank_pkg::gain_pair_t gain_q;
   cal_bank_pkg::check_status_t status_q;

   // unity gain out of reset, so the channels start untrimmed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_q <= '{ch1: cal_bank_pkg::GAIN_ONE, ch2: cal_bank_pkg::GAIN_ONE};
      end else begin
         gain_q <= gain_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------
   // apb response
   // ----------------------------------------
   // no wait state, yet read data and the error flag leave flip-flops
   // reserved bits read zero
   wire logic [7:0] reg_byte = regs_q[idx] & idx_mask;
   wire logic [7:0] rd_byte = is_status ? {5'h00, status_q} : reg_byte;
   wire logic rd_go = setup & ~pwrite & ~addr_err;
   wire logic [31:0] prdata_d = rd_go ? {24'h00_0000, rd_byte} : 32'h0000_0000;
   wire logic pslverr_d = setup & (addr_err | (pwrite & is_status));
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // ready answers every setup cycle after exactly one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign gain = gain_q;
   assign status = status_q;

endmodule

// ### tb/cal_bank_sva.sv
// port checker for the calibration register bank
`timescale 1ns/100ps
module cal_bank_sva #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire cal_bank_pkg::gain_pair_t gain,
   input wire cal_bank_pkg::check_status_t status
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // bus answer and field checks
   // ----------------------------------------
   a_ready_setup: assert property (psel && !penable |=> pready && psel && penable)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_align: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access accepted");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_ch1_resv: assert property (pready && !pwrite && paddr[8:0] == 9'h1dc |-> !prdata[6])
      else $error("ch1 reserved bit set");
   a_ch2_resv: assert property (pready && !pwrite && paddr[8:0] == 9'h1e0 |-> prdata[7:6] == 2'b00)
      else $error("ch2 reserved bit set");
   a_ch1_gain_step: assert property ((int'(gain.ch1) - 1024) % 5 == 0 && gain.ch1 >= 12'h360)
      else $error("ch1 gain off step");
   a_ch2_gain_step: assert property ((int'(gain.ch2) - 1024) % 5 == 0 && gain.ch2 <= 12'h49b)
      else $error("ch2 gain off step");
   c_read_ch1: cover property (pready && !pwrite && paddr[8:0] == 9'h1dc);
   c_refused: cover property (pready && pslverr);
   c_trimmed: cover property (gain.ch1 != 12'h400 && status.set_a_ok);
endmodule

bind color_calibration_register_bank cal_bank_sva #(.ADDR_W(ADDR_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gain(gain),
   .status(status));

// ### tb/testbench.sv
// self-checking bench for the calibration register bank
`timescale 1ns/100ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic [7:0] mem [128];
   logic [7:0] c;
   int n_mismatch = 0, compares = 0, t1, t2;
   cal_bank_pkg::gain_pair_t gain;
   cal_bank_pkg::check_status_t status;
   color_calibration_register_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gain(gain), .status(status));
   initial begin
      forever #10 pclk = ~pclk;
   end
   task automatic final_report;
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] x, input logic [31:0] y);
      compares++;
      if (y !== x) begin
         n_mismatch++;
         $display("Error %0t exp %h got %h", $time, x, y);
      end
   endtask
   // prdata and pslverr are read at the sampling edge, before its updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      apb(1'b1, {3'h0, i, 2'h0}, d);
      cmp(32'h0, pslverr);
      mem[i] = d & (i == 7'h77 ? 8'hbf : i == 7'h78 ? 8'h3f : 8'hff);
   endtask
   task automatic rd(input logic [6:0] i);
      apb(1'b0, {3'h0, i, 2'h0}, 8'h00);
      cmp({24'h0, mem[i]}, prdata);
      cmp(32'h0, pslverr);
   endtask
   // the scan period is 99 cycles, so 200 covers a full pass plus lag
   task automatic settle;
      repeat (200) @(posedge pclk);
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] d);
      s = s ^ d;
      repeat (8) s = s[7] ? {s[6:0], 1'b0} ^ 8'h07 : {s[6:0], 1'b0};
      return s;
   endfunction
   function automatic logic [7:0] crc_cfg;
      logic [7:0] s = 8'h00;
      for (int i = 0; i < 96; i++) s = crc8(s, mem[i]);
      return s;
   endfunction
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      void'($urandom(32'hb816c67c));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cmp(32'h400400, gain);
      rd(7'h77);
      rd(7'h78);
      for (int i = 0; i < 96; i++) wr(7'(i), 8'($urandom));
      wr(7'h46, mem[7'h46] & 8'hfe);
      wr(7'h66, ~crc_cfg());
      settle();
      cmp(32'h1, status.cfg_ok);
      wr(7'h46, mem[7'h46] | 8'h01);
      wr(7'h66, ~crc_cfg());
      settle();
      cmp(32'h0, status.cfg_ok);
      wr(7'h66, crc_cfg());
      settle();
      cmp(32'h1, status.cfg_ok);
      for (int i = 93; i < 95; i++) rd(7'(i));
      rd(7'h66);
      apb(1'b0, 12'h1c0, 8'h00);
      cmp(32'h1, pslverr);
      cmp(32'h0, prdata);
      apb(1'b0, 12'h1dd, 8'h00);
      cmp(32'h1, pslverr);
      apb(1'b1, 12'h1fc, 8'hff);
      cmp(32'h1, pslverr);
      for (int i = 0; i < 6; i++) begin
         t1 = (i == 0) ? -32 : (i == 1) ? 31 : int'($urandom_range(63)) - 32;
         t2 = (i == 0) ? 31 : (i == 1) ? -32 : int'($urandom_range(63)) - 32;
         wr(7'h77, {i != 2, 1'($urandom), 6'(t1)});
         wr(7'h78, {2'($urandom), 6'(t2)});
         rd(7'h77);
         rd(7'h78);
         c = crc8(crc8(8'h00, mem[119]), mem[120]);
         wr(7'h79, (i == 3) ? ~c : c);
         settle();
         cmp(12'(i < 2 || i > 3 ? 1024 + 5 * t1 : 1024), gain.ch1);
         cmp(12'(i < 2 || i > 3 ? 1024 + 5 * t2 : 1024), gain.ch2);
         cmp(i != 3, status.set_a_ok);
         cmp(i != 2 && i != 3, status.set_a_active);
         apb(1'b0, 12'h1fc, 8'h00);
         cmp({29'h0, i != 2 && i != 3, i != 3, 1'b1}, prdata);
      end
      final_report();
   end
endmodule
